// ### src/hdiv_core.sv
// Hardware divider: signed or unsigned 32-bit truncated division in eight cycles
`timescale 1ns/1ps
// Function
// RQ1: Divide 32-bit dividend by 32-bit divisor, signed or unsigned.
// RQ2: Quotient truncates toward zero; signed remainder follows dividend sign.
// RQ3: Division starts only on the start bit, never on operand writes.
// RQ4: Complete flag rises eight cycles after start.
// RQ5: Zero divisor at start raises the divide-by-zero flag.
// RQ6: Each operand loads in one clock cycle.
// RQ7: Sign-mode bit; results and flags hold until next start clears flags.
module hdiv_core (
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // Operand loading
  input wire logic dividend_we,
  input wire logic [31:0] dividend_wdata,
  input wire logic divisor_we,
  input wire logic [31:0] divisor_wdata,
  // Control
  input wire logic start,
  input wire logic signed_mode,
  // Results and status
  output hdiv_pkg::hdiv_result_t result,
  output hdiv_pkg::hdiv_flags_t flags,
  output logic busy
);
  // ==========================================
  // Operand registers
  logic [31:0] dividend;
  logic [31:0] divisor;

  // RQ6 one-cycle load
  hdiv_operand_reg #(.WIDTH(hdiv_pkg::DATA_W)) u_dividend (
    .clk(clk),
    .arst_n(arst_n),
    .load(dividend_we),
    .load_data(dividend_wdata),
    .value(dividend)
  );

  hdiv_operand_reg #(.WIDTH(hdiv_pkg::DATA_W)) u_divisor (
    .clk(clk),
    .arst_n(arst_n),
    .load(divisor_we),
    .load_data(divisor_wdata),
    .value(divisor)
  );

  // ==========================================
  // Helpers
  function automatic logic [31:0] hdiv_abs(input logic [31:0] v, input logic sgn);
    hdiv_abs = (sgn && v[31]) ? 32'(-v) : v;
  endfunction

  function automatic logic [31:0] hdiv_neg_if(input logic [31:0] v, input logic n);
    hdiv_neg_if = n ? 32'(-v) : v;
  endfunction

  // ==========================================
  // Sequencer
  typedef enum logic [0:0] {
    HDIV_IDLE = 1'b0,
    HDIV_CALC = 1'b1
  } hdiv_state_t;

  hdiv_state_t state;
  logic [3:0] cnt;
  logic [31:0] rem_acc;
  logic [31:0] quo_acc;
  logic [31:0] dsr_abs;
  logic neg_q;
  logic neg_r;
  logic is_zero;
  logic start_ok;

  // Start while busy is ignored so a running result is never corrupted
  assign start_ok = start && (state == HDIV_IDLE);
  assign busy = (state == HDIV_CALC);

  // RQ3 start bit only
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      state <= HDIV_IDLE;
    else
    begin
      case (state)
        HDIV_IDLE:
          if (start_ok)
            state <= HDIV_CALC;
        HDIV_CALC:
          if (cnt == hdiv_pkg::CNT_LAST)
            state <= HDIV_IDLE;
        default:
          state <= HDIV_IDLE;
      endcase
    end
  end

  // RQ4 eight cycle count
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      cnt <= 4'h0;
    else if (start_ok)
      cnt <= 4'h1;
    else if (state == HDIV_CALC)
      cnt <= 4'(cnt + 4'h1);
  end

  // ==========================================
  // Radix-16 datapath: four restoring steps per cycle, 8 cycles for 32 bits
  logic [31:0] step_rem [0:4];
  logic [31:0] step_quo [0:4];
  logic [32:0] trial;

  always_comb
  begin
    step_rem[0] = rem_acc;
    step_quo[0] = quo_acc;
    trial = 33'h0;
    for (int i = 0; i < 4; i++)
    begin
      trial = {step_rem[i], step_quo[i][31]} - {1'b0, dsr_abs};
      if (!trial[32])
      begin
        step_rem[i+1] = trial[31:0];
        step_quo[i+1] = {step_quo[i][30:0], 1'b1};
      end
      else
      begin
        step_rem[i+1] = {step_rem[i][30:0], step_quo[i][31]};
        step_quo[i+1] = {step_quo[i][30:0], 1'b0};
      end
    end
  end

  // RQ1 magnitude division
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rem_acc <= hdiv_pkg::OPERAND_RST;
      quo_acc <= hdiv_pkg::OPERAND_RST;
      dsr_abs <= hdiv_pkg::OPERAND_RST;
      neg_q <= 1'b0;
      neg_r <= 1'b0;
      is_zero <= 1'b0;
    end
    else if (start_ok)
    begin
      rem_acc <= 32'h00000000;
      quo_acc <= hdiv_abs(dividend, signed_mode);
      dsr_abs <= hdiv_abs(divisor, signed_mode);
      // RQ2 sign of results
      neg_q <= signed_mode && (dividend[31] ^ divisor[31]);
      neg_r <= signed_mode && dividend[31];
      is_zero <= (divisor == 32'h00000000);
    end
    else if (state == HDIV_CALC)
    begin
      rem_acc <= step_rem[4];
      quo_acc <= step_quo[4];
    end
  end

  // RQ2 truncated result out
  // Zero divisor result is left as the raw datapath output; only the flag is meaningful
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      result <= '0;
    else if (state == HDIV_CALC && cnt == hdiv_pkg::CNT_LAST)
    begin
      result.quotient <= hdiv_neg_if(step_quo[4], neg_q);
      result.remainder <= hdiv_neg_if(step_rem[4], neg_r);
    end
  end

  // RQ7 flags held, start clears
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      flags <= '0;
    else if (state == HDIV_CALC && cnt == hdiv_pkg::CNT_LAST)
    begin
      flags.done <= 1'b1;
      // RQ5 divide by zero flag
      flags.div_zero <= is_zero;
    end
    else if (start_ok)
      flags <= '0;
  end

  // ==========================================
  // Assertions
  property p_done_eight;
    @(posedge clk) disable iff (!arst_n)
    // Flags clear on the start edge, so the count begins one edge later
    start_ok |=> !flags.done [*8] ##1 flags.done;
  endproperty
  a_done_eight: assert property (p_done_eight) else $error("done not set eight cycles after start"); // RQ4

  property p_zero_flag;
    @(posedge clk) disable iff (!arst_n)
    (start_ok && divisor == 32'h00000000) |-> ##9 flags.div_zero;
  endproperty
  a_zero_flag: assert property (p_zero_flag) else $error("zero divisor not flagged"); // RQ5

  property p_nonzero_flag;
    @(posedge clk) disable iff (!arst_n)
    (start_ok && divisor != 32'h00000000) |-> ##9 !flags.div_zero;
  endproperty
  a_nonzero_flag: assert property (p_nonzero_flag) else $error("false divide by zero flag"); // RQ5

  property p_no_self_start;
    @(posedge clk) disable iff (!arst_n)
    (!busy && !start) |=> !busy;
  endproperty
  a_no_self_start: assert property (p_no_self_start) else $error("division began without start"); // RQ3

  property p_clear_on_start;
    @(posedge clk) disable iff (!arst_n)
    start_ok |=> !flags.done && !flags.div_zero;
  endproperty
  a_clear_on_start: assert property (p_clear_on_start) else $error("flags not cleared by start"); // RQ7

  property p_hold_result;
    @(posedge clk) disable iff (!arst_n)
    (!busy && !$past(busy)) |-> $stable(result) && $stable(flags);
  endproperty
  a_hold_result: assert property (p_hold_result) else $error("result changed while idle"); // RQ7

  property p_load_one;
    @(posedge clk) disable iff (!arst_n)
    dividend_we |=> dividend == $past(dividend_wdata);
  endproperty
  a_load_one: assert property (p_load_one) else $error("dividend load took more than one cycle"); // RQ6

  property p_unsigned_q;
    @(posedge clk) disable iff (!arst_n)
    (start_ok && !signed_mode && divisor != 32'h00000000) |->
      ##9 result.quotient == $past(dividend / divisor, 9);
  endproperty
  a_unsigned_q: assert property (p_unsigned_q) else $error("unsigned quotient wrong"); // RQ1

  property p_signed_q;
    @(posedge clk) disable iff (!arst_n)
    (start_ok && signed_mode && divisor != 32'h00000000 &&
      !(dividend == 32'h80000000 && divisor == 32'hFFFFFFFF)) |->
      ##9 result.quotient == $past(32'($signed(dividend) / $signed(divisor)), 9) &&
      result.remainder == $past(32'($signed(dividend) % $signed(divisor)), 9);
  endproperty
  a_signed_q: assert property (p_signed_q) else $error("signed result wrong"); // RQ2

  c_unsigned: cover property (@(posedge clk) disable iff (!arst_n) start_ok && !signed_mode ##9 flags.done);
  c_signed: cover property (@(posedge clk) disable iff (!arst_n) start_ok && signed_mode ##9 flags.done);
  c_zero: cover property (@(posedge clk) disable iff (!arst_n) flags.div_zero);
  c_busy_start: cover property (@(posedge clk) disable iff (!arst_n) busy && start);
endmodule

// ### src/hdiv_operand_reg.sv
// Operand store: one cycle load of dividend or divisor
`timescale 1ns/1ps
module hdiv_operand_reg #(
  parameter int unsigned WIDTH = 32
) (
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // Load port
  input wire logic load,
  input wire logic [WIDTH-1:0] load_data,
  // Stored value
  output logic [WIDTH-1:0] value
);
  // Value taken on the load edge, so a new one can land each cycle
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      value <= '0;
    else if (load)
      value <= load_data;
  end
endmodule

// ### src/hdiv_pkg.sv
// Package: constants and carrier types of the hardware divider
package hdiv_pkg;
  // ==========================================
  // Sizes and timing
  localparam int unsigned DATA_W = 32;
  localparam int unsigned CALC_CYCLES = 8;
  localparam int unsigned CNT_W = 4;
  localparam logic [3:0] CNT_LAST = 4'h8;
  localparam logic [31:0] OPERAND_RST = 32'h00000000;

  // ==========================================
  // Carriers
  typedef struct packed {
    logic [31:0] quotient;
    logic [31:0] remainder;
  } hdiv_result_t;

  typedef struct packed {
    logic done;
    logic div_zero;
  } hdiv_flags_t;
endpackage

// ### testbench/hardware_divider_test.sv
// Self-checking bench for the hardware divider
`timescale 1ns/1ps
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin miscompares++; \
  $display("CHECK FAILED at %0t: got %h expected %h", $time, (a), (b)); end end
module hardware_divider_test;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic dividend_we, divisor_we, start, signed_mode, busy, clr;
  logic [31:0] dividend_wdata;
  logic [31:0] divisor_wdata;
  hdiv_pkg::hdiv_result_t result;
  hdiv_pkg::hdiv_flags_t flags;
  int miscompares = 0;
  int check_count = 0;
  int cyc;
  longint sa, sb;
  // Cases: dividend, divisor, signed mode; last has a zero divisor
  logic [31:0] ta [7] = '{32'h64, 32'hFFFFFFFF, 32'hFFFFFFF9, 32'h7, 32'h80000000, 32'hFFFFFFF9, 32'h5};
  logic [31:0] tb [7] = '{32'h7, 32'h2, 32'h2, 32'hFFFFFFFE, 32'hFFFFFFFF, 32'h2, 32'h0};
  logic ts [7] = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0};

  // ==========================================
  // Clock and design
  always #2.5 clk = ~clk;

  hdiv_core u_hdiv_core (.clk(clk), .arst_n(arst_n), .dividend_we(dividend_we),
    .dividend_wdata(dividend_wdata), .divisor_we(divisor_we), .divisor_wdata(divisor_wdata),
    .start(start), .signed_mode(signed_mode), .result(result), .flags(flags), .busy(busy));

  hdiv_cpu_model u_hdiv_cpu_model (.clk(clk), .dividend_we(dividend_we), .dividend_wdata(dividend_wdata),
    .divisor_we(divisor_we), .divisor_wdata(divisor_wdata), .start(start), .signed_mode(signed_mode),
    .busy(busy), .flags(flags));

  // Counts and verdict, also reached when a wait runs out
  task automatic give_verdict();
    $display("Comparisons %0d, mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // ==========================================
  // Main sequence
  initial
  begin
    repeat (3) @(posedge clk);
    #1 arst_n = 1'b1;
    `CHK({result, flags, busy}, 67'h0)
    // Operand writes alone must not launch anything
    u_hdiv_cpu_model.divide(32'h64, 32'h7, 1'b0, 1'b0, 1'b0, cyc, clr);
    repeat (3) @(posedge clk);
    #1 `CHK({flags, busy}, 3'h0)
    $display("Test no-start finished");
    for (int i = 0; i < 7; i++)
    begin
      u_hdiv_cpu_model.divide(ta[i], tb[i], ts[i], 1'b1, i == 2, cyc, clr);
      `CHK(clr, 1'b1)
      // Edges counted from the start edge until done shows
      `CHK(cyc, hdiv_pkg::CALC_CYCLES)
      if (cyc >= 20)
        break;
      // Outputs must hold while idle
      repeat (3) @(posedge clk);
      #1 `CHK(flags, {1'b1, tb[i] == 32'h0})
      sa = ts[i] ? longint'($signed(ta[i])) : longint'(ta[i]);
      sb = ts[i] ? longint'($signed(tb[i])) : longint'(tb[i]);
      if (sb != 0)
      begin
        `CHK(result.quotient, 32'(sa / sb))
        `CHK(result.remainder, 32'(sa % sb))
      end
      $display("Test %0d finished", i);
    end
    give_verdict();
  end
endmodule

// ### testbench/hdiv_cpu_model.sv
// Processor-side model that loads operands and starts divisions
`timescale 1ns/1ps
module hdiv_cpu_model (
  // Clock
  input wire logic clk,
  // Divider inputs
  output logic dividend_we,
  output logic [31:0] dividend_wdata,
  output logic divisor_we,
  output logic [31:0] divisor_wdata,
  output logic start,
  output logic signed_mode,
  // Divider status
  input wire logic busy,
  input wire hdiv_pkg::hdiv_flags_t flags
);
  // ==========================================
  // Idle levels at time zero
  initial
  begin
    {dividend_we, divisor_we, start, signed_mode} = 4'h0;
    dividend_wdata = 32'h0;
    divisor_wdata = 32'h0;
  end

  // Load, optionally start, then count cycles to completion; poke retries start mid-run
  task automatic divide(input logic [31:0] a, input logic [31:0] b, input logic sm,
                        input logic go, input logic poke, output int cyc, output logic clr);
    cyc = 0;
    @(posedge clk) #1;
    dividend_we = 1'b1;
    dividend_wdata = a;
    @(posedge clk) #1;
    dividend_we = 1'b0;
    dividend_wdata = ~a;
    divisor_we = 1'b1;
    divisor_wdata = b;
    @(posedge clk) #1;
    divisor_we = 1'b0;
    divisor_wdata = ~b;
    start = go;
    signed_mode = sm;
    @(posedge clk) #1;
    start = 1'b0;
    // Mode flips so a late sample would show
    signed_mode = ~sm;
    clr = go & busy & ~flags.done & ~flags.div_zero;
    while (go && !flags.done && cyc < 20)
    begin
      cyc++;
      start = poke && cyc == 3;
      dividend_we = start;
      @(posedge clk) #1;
    end
    start = 1'b0;
    dividend_we = 1'b0;
  endtask
endmodule
